/* fsi_pkg.sv */
// Package of constants and carriers for the fiber status and identifier register bank
// Operation
// - 100BASE-X duplex abilities set only in mode 00
// - Negotiation ability clear in mode 00, else set
// - Unsupported abilities and reserved bits read zero
// - Extended status and capability bits read one
// - Preamble suppression bit reads one always
// - Negotiation complete only after real negotiation finish
// - Remote fault latches high until status read
// - Remote fault forced zero in SGMII modes
// - Link status latches low until status read
// - Identifier high holds organization bits 3 to 18
// - Identifier low holds organization, model, revision fields
package fsi_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [3:0] FSI_IDX_STATUS = 4'h1;
  localparam logic [3:0] FSI_IDX_ID_HIGH = 4'h2;
  localparam logic [3:0] FSI_IDX_ID_LOW = 4'h3;
  localparam logic [3:0] FSI_IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] FSI_IDX_IRQ_ENABLE = 4'h9;
  localparam logic [3:0] FSI_IDX_IRQ_CLEAR = 4'hA;
  // Status register bit positions
  localparam int FSI_BIT_FD100 = 14;
  localparam int FSI_BIT_HD100 = 13;
  localparam int FSI_BIT_EXT_STATUS = 8;
  localparam int FSI_BIT_NO_PREAMBLE = 6;
  localparam int FSI_BIT_AN_DONE = 5;
  localparam int FSI_BIT_REMOTE_FAULT = 4;
  localparam int FSI_BIT_AN_ABILITY = 3;
  localparam int FSI_BIT_LINK = 2;
  localparam int FSI_BIT_EXT_CAP = 0;
  // Fiber mode codes
  localparam logic [1:0] FSI_MODE_100FX = 2'h0;
  localparam logic [1:0] FSI_MODE_SGMII_SYS = 2'h2;
  localparam logic [1:0] FSI_MODE_SGMII_MEDIA = 2'h3;
  // Identifier field reset values; arbitrary neutral values
  localparam logic [15:0] FSI_OUI_HIGH_RST = 16'h1234;
  localparam logic [5:0] FSI_OUI_LOW_RST = 6'h15;
  localparam logic [5:0] FSI_MODEL_RST = 6'h2A;
  localparam logic [3:0] FSI_REV_RST = 4'h1;
  // Bus answer for unmapped reads
  localparam logic [31:0] FSI_UNMAPPED_DATA = 32'h0000_0000;
  // Interrupt event bit positions
  localparam int FSI_EV_LINK_LOST = 0;
  localparam int FSI_EV_FAULT = 1;
  localparam int FSI_EV_AN_DONE = 2;
  localparam int FSI_EV_COUNT = 3;

  // Avalon request carrier
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fsi_req_s;

  // Live condition inputs from the fiber side
  typedef struct packed {
    logic [1:0] mode;
    logic link_live;
    logic fault_live;
    logic an_done_live;
    logic an_bypass;
    logic an_disabled;
  } fsi_live_s;
endpackage : fsi_pkg

/* fsi_latch.sv */
// Latching flag that holds an event until the status register is read
`timescale 1ns/1ps
`default_nettype none
module fsi_latch
  import fsi_pkg::*;
#(
  parameter logic ACTIVE = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic live,
  input wire logic read_ack,
  output logic flag
);
  // Flag state: latched marks an event held since last read
  typedef struct packed {
    logic latched;
    logic flag;
  } fsi_latch_s;
  fsi_latch_s state;
  fsi_latch_s next_state;

  // A live event wins over a read in the same cycle, so nothing is lost
  always_comb
  begin
    next_state = state;
    if (live == ACTIVE)
    begin
      next_state.latched = 1'b1;
      next_state.flag = ACTIVE;
    end
    else if (read_ack)
    begin
      next_state.latched = 1'b0;
      next_state.flag = live;
    end
    else if (!state.latched)
    begin
      next_state.flag = live; // Follows live until an event
    end
  end

  // Reset drives flag to zero for both polarities.
  // A latch-low flag also starts latched, so its zero holds until the first read.
  // Otherwise, with the link already up, it would read one straight after reset.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state <= '{latched: (ACTIVE == 1'b0), flag: 1'b0};
    else
      state <= next_state;
  end

  assign flag = state.flag;
endmodule : fsi_latch
`default_nettype wire

/* fsi_event_irq.sv */
// Sticky interrupt status, enable and clear registers with one level output
`timescale 1ns/1ps
`default_nettype none
module fsi_event_irq
  import fsi_pkg::*;
#(
  parameter int N = FSI_EV_COUNT
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N-1:0] event_pulse,
  input wire logic enable_we,
  input wire logic clear_we,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
  } fsi_irq_s;
  fsi_irq_s state;
  fsi_irq_s next_state;

  // A set in the clearing cycle wins over the clear
  always_comb
  begin
    next_state = state;
    if (clear_we)
      next_state.status = state.status & ~wdata;
    next_state.status = next_state.status | event_pulse;
    if (enable_we)
      next_state.enable = wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign status = state.status;
  assign enable = state.enable;
  // Level output while any enabled bit is pending
  assign irq = |(state.status & state.enable);
endmodule : fsi_event_irq
`default_nettype wire

/* fsi_regs.sv */
// Fiber status and identifier register bank on an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module fsi_regs
  import fsi_pkg::*;
#(
  parameter logic [15:0] OUI_HIGH = FSI_OUI_HIGH_RST,
  parameter logic [5:0] OUI_LOW = FSI_OUI_LOW_RST,
  parameter logic [5:0] MODEL = FSI_MODEL_RST,
  parameter logic [3:0] REVISION = FSI_REV_RST
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_rst,
  input wire fsi_pkg::fsi_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire fsi_pkg::fsi_live_s live,
  output logic irq
);
  // Bus handshake phases: one idle cycle, then the answer cycle
  typedef enum logic [0:0] {FSI_IDLE, FSI_DONE} fsi_phase_e;

  // Bus phase, read data and completion bit in one struct
  typedef struct packed {
    fsi_phase_e phase;
    logic [31:0] readdata;
    logic an_done;
  } fsi_state_s;
  fsi_state_s state;
  fsi_state_s next_state;

  logic fault_flag; // Latched-high remote fault
  logic link_flag; // Latched-low link
  logic status_read; // One-cycle pulse when status read completes
  logic [15:0] status_word;
  logic [FSI_EV_COUNT-1:0] irq_status;
  logic [FSI_EV_COUNT-1:0] irq_enable;
  logic [FSI_EV_COUNT-1:0] events;
  logic sgmii;
  logic fault_in;
  logic any_rst;
  logic link_prev;
  logic fault_prev;
  logic an_prev;
  logic take;

  // Decode shared by reads and writes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction : hit

  // Both resets clear the latches and the completion bit
  assign any_rst = rst | soft_rst;
  assign sgmii = (live.mode == FSI_MODE_SGMII_SYS) || (live.mode == FSI_MODE_SGMII_MEDIA);
  assign fault_in = live.fault_live & ~sgmii;
  assign take = (state.phase == FSI_DONE);
  assign status_read = take & avs_req.read & hit(avs_req.address, FSI_IDX_STATUS);

  fsi_latch #(.ACTIVE(1'b1)) u_fault (
    .clk_sys(clk_sys),
    .rst(any_rst),
    .live(fault_in),
    .read_ack(status_read),
    .flag(fault_flag)
  );

  fsi_latch #(.ACTIVE(1'b0)) u_link (
    .clk_sys(clk_sys),
    .rst(any_rst),
    .live(live.link_live),
    .read_ack(status_read),
    .flag(link_flag)
  );

  // Composing the status word from live mode and latched flags
  always_comb
  begin
    status_word = 16'h0000;
    status_word[FSI_BIT_FD100] = (live.mode == FSI_MODE_100FX);
    status_word[FSI_BIT_HD100] = (live.mode == FSI_MODE_100FX);
    status_word[FSI_BIT_EXT_STATUS] = 1'b1;
    status_word[FSI_BIT_NO_PREAMBLE] = 1'b1;
    status_word[FSI_BIT_AN_DONE] = state.an_done;
    status_word[FSI_BIT_REMOTE_FAULT] = fault_flag & ~sgmii;
    status_word[FSI_BIT_AN_ABILITY] = (live.mode != FSI_MODE_100FX);
    status_word[FSI_BIT_LINK] = link_flag;
    status_word[FSI_BIT_EXT_CAP] = 1'b1;
  end

  // Edge detect for interrupt events; plain registers, inputs are synchronous
  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
    begin
      link_prev <= 1'b0;
      fault_prev <= 1'b0;
      an_prev <= 1'b0;
    end
    else
    begin
      link_prev <= live.link_live;
      fault_prev <= fault_in;
      an_prev <= state.an_done;
    end
  end

  always_comb
  begin
    events = '0;
    events[FSI_EV_LINK_LOST] = link_prev & ~live.link_live;
    events[FSI_EV_FAULT] = fault_in & ~fault_prev;
    events[FSI_EV_AN_DONE] = state.an_done & ~an_prev;
  end

  fsi_event_irq #(.N(FSI_EV_COUNT)) u_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .event_pulse(events),
    .enable_we(take & avs_req.write & hit(avs_req.address, FSI_IDX_IRQ_ENABLE)),
    .clear_we(take & avs_req.write & hit(avs_req.address, FSI_IDX_IRQ_CLEAR)),
    .wdata(avs_req.writedata[FSI_EV_COUNT-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // Bus phase, read data and completion bit
  always_comb
  begin
    next_state = state;
    // Completion only from a finished negotiation, never bypass or disabled
    next_state.an_done = live.an_done_live & ~live.an_bypass & ~live.an_disabled;
    // Software reset clears completion; bus phase and read data are left alone
    if (soft_rst)
      next_state.an_done = 1'b0;
    case (state.phase)
      FSI_IDLE:
      begin
        if (avs_req.read || avs_req.write)
        begin
          next_state.phase = FSI_DONE;
          // Capture read data now so it stands stable in the answer cycle
          if (hit(avs_req.address, FSI_IDX_STATUS))
            next_state.readdata = {16'h0000, status_word};
          else if (hit(avs_req.address, FSI_IDX_ID_HIGH))
            next_state.readdata = {16'h0000, OUI_HIGH};
          else if (hit(avs_req.address, FSI_IDX_ID_LOW))
            next_state.readdata = {16'h0000, OUI_LOW, MODEL, REVISION};
          else if (hit(avs_req.address, FSI_IDX_IRQ_STATUS))
            next_state.readdata = {{(32-FSI_EV_COUNT){1'b0}}, irq_status};
          else if (hit(avs_req.address, FSI_IDX_IRQ_ENABLE))
            next_state.readdata = {{(32-FSI_EV_COUNT){1'b0}}, irq_enable};
          else
            next_state.readdata = FSI_UNMAPPED_DATA;
        end
      end
      FSI_DONE:
      begin
        next_state.phase = FSI_IDLE;
      end
      default:
      begin
        next_state.phase = FSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Waitrequest high except in the answer cycle
  assign avs_waitrequest = ~take;
  assign avs_readdata = state.readdata;
endmodule : fsi_regs
`default_nettype wire

/* fsi_regs_asserts.sv */
// Checker of bus timing and status and identifier fields of the register bank
`timescale 1ns/1ps
`default_nettype none
module fsi_regs_asserts
  import fsi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_rst,
  input wire fsi_pkg::fsi_req_s avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire fsi_pkg::fsi_live_s live,
  input wire logic irq
);
  // Answer cycle of a read, and of a status read in particular
  logic rd;
  logic st;
  // Negotiation held off by bypass or disable
  logic blk;
  assign rd = avs_req.read && !avs_waitrequest;
  assign st = rd && avs_req.address == FSI_IDX_STATUS;
  assign blk = live.an_bypass | live.an_disabled;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_one_wait: assert property (avs_req.read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read answer late");
  a_idle_wait: assert property (!avs_req.read && !avs_req.write |-> avs_waitrequest)
    else $error("answer without request");
  a_zero_bits: assert property (st |-> (avs_readdata & 32'hFFFF_9E82) == 32'h0)
    else $error("unsupported bit set");
  a_one_bits: assert property (st |-> avs_readdata[8] && avs_readdata[0])
    else $error("extended bits clear");
  a_no_preamble: assert property (st |-> avs_readdata[6])
    else $error("preamble bit clear");
  a_duplex_mode: assert property (st |-> avs_readdata[14:13] ==
    {2{$past(live.mode) == FSI_MODE_100FX}}) else $error("duplex bits wrong");
  a_an_ability: assert property (st |-> avs_readdata[3] ==
    ($past(live.mode) != FSI_MODE_100FX)) else $error("ability bit wrong");
  a_sgmii_fault: assert property (st && $past(live.mode[1]) |-> !avs_readdata[4])
    else $error("fault shown in serial mode");
  a_an_blocked: assert property (st && $past(blk, 2) |-> !avs_readdata[5])
    else $error("complete while bypassed");
  a_id_high: assert property (rd && avs_req.address == FSI_IDX_ID_HIGH |->
    avs_readdata == {16'h0, FSI_OUI_HIGH_RST}) else $error("id high wrong");
  a_id_low: assert property (rd && avs_req.address == FSI_IDX_ID_LOW |->
    avs_readdata == {16'h0, FSI_OUI_LOW_RST, FSI_MODEL_RST, FSI_REV_RST})
    else $error("id low wrong");
endmodule : fsi_regs_asserts
bind fsi_regs fsi_regs_asserts i_fsi_regs_asserts (.clk_sys, .rst, .soft_rst, .avs_req,
  .avs_readdata, .avs_waitrequest, .live, .irq);
`default_nettype wire

/* fsi_host_model.sv */
// Management host model issuing single Avalon-MM transfers
`timescale 1ns/1ps
`default_nettype none
module fsi_host_model
  import fsi_pkg::*;
(
  input wire logic clk_sys,
  output var fsi_pkg::fsi_req_s avs_req,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata
);
  initial avs_req = '0;
  // Holds the request until waitrequest is seen low; bounded so a hang ends
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk_sys);
    avs_req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hF};
    ok = 0;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_sys);
      ok = !avs_waitrequest;
    end
    q = avs_readdata;
    avs_req <= '0;
  endtask : xfer
endmodule : fsi_host_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the fiber status and identifier register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsi_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic soft_rst = 0;
  fsi_req_s avs_req;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fsi_live_s live = '0;
  logic irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 84;
  // Reference: latched link, latched fault, irq status, enable, edge history
  int lk, fl, ist, ien, pl, pf, pa;
  logic [31:0] q;
  logic [31:0] rn;
  fsi_live_s v;
  bit ok;
  always #12.5 clk_sys = ~clk_sys;
  fsi_regs i_fsi_regs (.clk_sys, .rst, .soft_rst, .avs_req, .avs_readdata,
    .avs_waitrequest, .live, .irq);
  fsi_host_model i_fsi_host_model (.clk_sys, .avs_req, .avs_waitrequest, .avs_readdata);
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // A lost handshake ends the run
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    i_fsi_host_model.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t no bus answer", $time);
      summarize();
    end
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    acc(0, a, 32'h0);
    cmp(q, exp);
  endtask : rd
  // Status read; latches then re-arm to the live levels
  task automatic rd_status();
    rd(FSI_IDX_STATUS, 32'h0000_0141 | {17'h0, {2{live.mode == 2'h0}}, 7'h0,
      live.an_done_live & !live.an_bypass & !live.an_disabled, fl[0] & !live.mode[1],
      live.mode != 2'h0, lk[0], 2'h0});
    lk = live.link_live;
    fl = live.fault_live & !live.mode[1];
  endtask : rd_status
  // New live levels; events update the reference first
  task automatic set_live(input fsi_live_s s);
    int ad;
    ad = s.an_done_live & !s.an_bypass & !s.an_disabled;
    if (pl && !s.link_live) ist |= 1;
    if (!pf && s.fault_live) ist |= 2;
    if (!pa && ad) ist |= 4;
    pl = s.link_live;
    pf = s.fault_live;
    pa = ad;
    if (!s.link_live) lk = 0;
    if (s.fault_live) fl = 1;
    live <= s;
    repeat (3) @(posedge clk_sys);
  endtask : set_live
  task automatic chk_irq();
    rd(FSI_IDX_IRQ_STATUS, ist);
    cmp(irq, |(ist & ien));
  endtask : chk_irq
  initial
  begin
    {lk, fl, ist, ien, pl, pf, pa} = '0;
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    rd_status();
    rd(FSI_IDX_ID_HIGH, {16'h0, FSI_OUI_HIGH_RST});
    acc(1, FSI_IDX_ID_LOW, 32'hFFFF_FFFF);
    acc(1, 4'h5, 32'hFFFF_FFFF);
    rd(FSI_IDX_ID_LOW, {16'h0, FSI_OUI_LOW_RST, FSI_MODEL_RST, FSI_REV_RST});
    rd(4'h5, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      rn = $random(seed);
      v = rn[6:0];
      // Fault only outside serial modes keeps its edge unambiguous
      if (v.mode[1]) v.fault_live = 0;
      set_live(v);
      rd_status();
      if (rn[9]) rd_status();
      chk_irq();
      acc(1, FSI_IDX_IRQ_CLEAR, {29'h0, rn[12:10]});
      ist &= ~int'(rn[12:10]);
      acc(1, FSI_IDX_IRQ_ENABLE, {29'h0, rn[15:13]});
      ien = rn[15:13];
      chk_irq();
    end
    set_live('{mode: 2'h0, link_live: 1'b1, default: 1'b0});
    soft_rst <= 1;
    @(posedge clk_sys);
    soft_rst <= 0;
    repeat (3) @(posedge clk_sys);
    lk = 0;
    fl = 0;
    rd_status();
    rd_status();
    chk_irq();
    summarize();
  end
endmodule : tb
`default_nettype wire
